/* rtl/switch_point_link_device.sv */
`timescale 1ns/1ps
`include "switch_point_link_params.svh"

// Behaviour
// RULE_01 - link mode sends 16-bit word: value 15..2, point two bit 1, one bit 0
// RULE_02 - two lowest word bits always mirror current switching point states
// RULE_03 - value in mbar: unsigned vacuum, unsigned pressure, or signed combined
// RULE_04 - link mode disables second output; first pin becomes the data line
// RULE_05 - switching mode: both outputs follow logical switching point states
// RULE_06 - each arising warning or error is reported to master as event
// RULE_07 - every setting readable and writable through indexed parameter channel
// RULE_08 - master writes value 5 to index 2; device then requests storage
// RULE_09 - menu or contactless parameter changes automatically request storage
// RULE_10 - control program writes alone never request automatic storage
// RULE_11 - master needs revision 1.1 and data storage enabled for mirroring
// RULE_12 - supply lost within three seconds of a change flags data loss
// RULE_13 - user text kept in non-volatile parameter store, master accessible
// RULE_14 - contactless parameter access works without device supply voltage
// RULE_15 - link runs at 38.4 kbit/s; master cycle at least 2.3 ms
// RULE_16 - switching point bit reads 1 when active, 0 when inactive
module switch_point_link_device
    import switch_point_link_pkg::*;
#(
    parameter switch_point_link_pkg::variant_t VARIANT = VARIANT_VACUUM,
    parameter int PARAM_DEPTH = `PARAM_DEPTH,
    parameter int NUM_FAULTS = 8,
    parameter int SETTLE_CYCLES = (`CLK_HZ / 1000) * `SETTLE_MS,
    parameter int MIN_CYCLE_CYCLES =
        (`MIN_CYCLE_US * (`CLK_HZ / 1000000) + 0),
    parameter int BIT_CYCLES = `CLK_HZ / `LINK_BIT_RATE
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // switching point inputs
    input wire logic point_one_state,
    input wire logic point_two_state,
    input wire logic signed [15:0] meas_mbar,
    input wire logic link_mode,
    // output pins
    output logic switch_out_first,
    output logic switch_out_first_oe,
    output logic switch_out_second,
    // cyclic frame request from the link layer
    input wire logic pd_request,
    // acyclic parameter channel from the master
    input wire switch_point_link_pkg::param_req_t master_req,
    output logic master_ack,
    output logic [15:0] master_rdata,
    // local menu and contactless tag writes
    input wire switch_point_link_pkg::param_req_t local_req,
    // events towards the master
    input wire logic [NUM_FAULTS-1:0] fault_level,
    output switch_point_link_pkg::event_t event_out,
    input wire logic event_ack,
    // storage request and supply watch
    output logic store_request,
    input wire logic store_ack,
    input wire logic supply_lost,
    output logic param_loss_error,
    input wire logic param_loss_clear
);
    import switch_point_link_pkg::*;

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
    localparam int CYC_W = $clog2(MIN_CYCLE_CYCLES + 1);
    localparam int BIT_W = $clog2(BIT_CYCLES + 1);
    localparam int IDX_W = $clog2(PARAM_DEPTH);

    // refuse values the counters and store cannot serve
    if (SETTLE_CYCLES < 1 || MIN_CYCLE_CYCLES < 1 || BIT_CYCLES < 2)
        $error("timing counts must be positive");
    if (PARAM_DEPTH < 4 || PARAM_DEPTH > 256 || NUM_FAULTS < 1 ||
        NUM_FAULTS > 8)
        $error("parameter depth or fault count out of range");

    // saturate the raw value into the 14-bit field per variant
    function automatic logic [13:0] encode_meas(input logic signed [15:0] v);
        logic signed [15:0] t;
        t = (VARIANT == VARIANT_VACUUM) ? -v : v;
        if (VARIANT == VARIANT_COMBINED)
        begin
            if (t > 16'sh1FFF)
                encode_meas = 14'h1FFF;
            else if (t < -16'sh2000)
                encode_meas = 14'h2000;
            else
                encode_meas = t[13:0];
        end
        else if (t < 16'sh0000)
            encode_meas = 14'h0000;
        else if (t > 16'sh3FFF)
            encode_meas = 14'h3FFF;
        else
            encode_meas = t[13:0];
    endfunction

    // ---- cyclic word and serial shifter ----
    tx_state_t tx_state, next_tx_state;
    pd_word_t tx_word, next_tx_word;
    logic [3:0] tx_bit, next_tx_bit;
    logic [BIT_W-1:0] bit_cnt, next_bit_cnt;
    logic [CYC_W-1:0] cyc_cnt, next_cyc_cnt;
    logic cycle_short, next_cycle_short;
    logic bit_tick;
    pd_word_t live_word;

    always_comb
    begin
        live_word.meas = encode_meas(meas_mbar); // see RULE_03
        live_word.sp2 = point_two_state; // see RULE_02
        live_word.sp1 = point_one_state; // see RULE_16
    end

    assign bit_tick = (bit_cnt == BIT_W'(BIT_CYCLES - 1)); // see RULE_15

    // word is latched at request so one frame never mixes two samples
    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_word = tx_word;
        next_tx_bit = tx_bit;
        next_bit_cnt = bit_tick ? '0 : bit_cnt + 1'b1;
        next_cyc_cnt = (cyc_cnt == CYC_W'(MIN_CYCLE_CYCLES)) ?
            cyc_cnt : cyc_cnt + 1'b1;
        next_cycle_short = 1'b0;
        case (tx_state)
            TX_IDLE:
            begin
                if (pd_request && link_mode)
                begin
                    next_tx_word = live_word; // see RULE_01
                    next_tx_bit = 4'hF;
                    next_bit_cnt = '0;
                    next_cyc_cnt = '0;
                    next_cycle_short =
                        (cyc_cnt < CYC_W'(MIN_CYCLE_CYCLES)); // see RULE_15
                    next_tx_state = TX_SHIFT;
                end
            end
            TX_SHIFT:
            begin
                if (!link_mode)
                    next_tx_state = TX_IDLE;
                else if (bit_tick)
                begin
                    next_tx_bit = tx_bit - 1'b1;
                    if (tx_bit == 4'h0)
                        next_tx_state = TX_DONE;
                end
            end
            TX_DONE:
                next_tx_state = TX_IDLE;
            default:
                next_tx_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_state <= TX_IDLE;
            tx_word <= '0;
            tx_bit <= 4'h0;
            bit_cnt <= '0;
            cyc_cnt <= CYC_W'(MIN_CYCLE_CYCLES);
            cycle_short <= 1'b0;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_word <= next_tx_word;
            tx_bit <= next_tx_bit;
            bit_cnt <= next_bit_cnt;
            cyc_cnt <= next_cyc_cnt;
            cycle_short <= next_cycle_short;
        end
    end

    // ---- pin routing ----
    logic next_out_first, next_out_first_oe, next_out_second;

    always_comb
    begin
        if (link_mode)
        begin
            next_out_first = (tx_state == TX_SHIFT) ?
                tx_word[tx_bit] : 1'b0; // see RULE_04
            next_out_first_oe = (tx_state == TX_SHIFT);
            next_out_second = 1'b0; // see RULE_04
        end
        else
        begin
            next_out_first = point_one_state; // see RULE_05
            next_out_first_oe = 1'b1;
            next_out_second = point_two_state; // see RULE_05
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            switch_out_first <= 1'b0;
            switch_out_first_oe <= 1'b0;
            switch_out_second <= 1'b0;
        end
        else
        begin
            switch_out_first <= next_out_first;
            switch_out_first_oe <= next_out_first_oe;
            switch_out_second <= next_out_second;
        end
    end

    // ---- parameter store ----
    // user text lives here too; the array stands in for non-volatile cells
    logic [15:0] params [PARAM_DEPTH];
    logic next_ack;
    logic [15:0] next_rdata;
    logic master_wr, local_wr, master_store_cmd;

    // the system command index is a trigger, not a stored setting
    assign master_store_cmd = master_req.valid && master_req.write &&
        master_req.index == `SYS_CMD_INDEX &&
        master_req.data == `CMD_STORE; // see RULE_08
    assign master_wr = master_req.valid && master_req.write &&
        master_req.index != `SYS_CMD_INDEX &&
        {1'b0, master_req.index} < 9'(PARAM_DEPTH); // see RULE_07
    // local writes lose a clash with the master in the same cycle
    assign local_wr = local_req.valid && local_req.write && !master_wr &&
        local_req.index != `SYS_CMD_INDEX &&
        {1'b0, local_req.index} < 9'(PARAM_DEPTH); // see RULE_14

    always_comb
    begin
        next_ack = master_req.valid;
        next_rdata = 16'h0000;
        if (master_req.valid && !master_req.write &&
            {1'b0, master_req.index} < 9'(PARAM_DEPTH))
            next_rdata = params[master_req.index[IDX_W-1:0]]; // see RULE_13
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            master_ack <= 1'b0;
            master_rdata <= 16'h0000;
        end
        else
        begin
            master_ack <= next_ack;
            master_rdata <= next_rdata;
        end
    end

    // store contents survive reset, as non-volatile cells would
    always_ff @(posedge clk)
    begin
        if (master_wr)
            params[master_req.index[IDX_W-1:0]] <= master_req.data;
        else if (local_wr)
            params[local_req.index[IDX_W-1:0]] <= local_req.data;
    end

    // ---- storage request and supply watch ----
    logic next_store_request, next_loss;
    logic [CNT_W-1:0] settle_cnt, next_settle_cnt;
    logic any_change;

    assign any_change = master_wr || local_wr;

    // a new trigger in the ack cycle keeps the request standing
    always_comb
    begin
        next_store_request = store_request;
        if (store_ack)
            next_store_request = 1'b0;
        if (master_store_cmd || local_wr) // see RULE_09
            next_store_request = 1'b1; // see RULE_10
        next_settle_cnt = settle_cnt;
        if (any_change)
            next_settle_cnt = CNT_W'(SETTLE_CYCLES); // see RULE_12
        else if (settle_cnt != '0)
            next_settle_cnt = settle_cnt - 1'b1;
        next_loss = param_loss_error;
        if (param_loss_clear)
            next_loss = 1'b0;
        if (supply_lost && (settle_cnt != '0 || any_change))
            next_loss = 1'b1; // see RULE_12
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            store_request <= 1'b0;
            settle_cnt <= '0;
            param_loss_error <= 1'b0;
        end
        else
        begin
            store_request <= next_store_request;
            settle_cnt <= next_settle_cnt;
            param_loss_error <= next_loss;
        end
    end

    // ---- events ----
    logic [NUM_FAULTS-1:0] fault_prev, next_fault_prev;
    logic [NUM_FAULTS-1:0] pending, next_pending;
    logic short_pend, next_short_pend, loss_pend, next_loss_pend;
    event_t next_event;

    // one event presented at a time; lowest fault number goes first
    always_comb
    begin
        next_fault_prev = fault_level;
        next_pending = pending;
        next_short_pend = short_pend;
        next_loss_pend = loss_pend;
        next_event = event_out;
        if (event_out.valid && event_ack)
            next_event.valid = 1'b0;
        if (!next_event.valid)
        begin
            if (loss_pend)
            begin
                next_event = '{valid: 1'b1, code: `EVT_PARAM_LOSS};
                next_loss_pend = 1'b0;
            end
            else if (short_pend)
            begin
                next_event = '{valid: 1'b1, code: `EVT_CYCLE_SHORT};
                next_short_pend = 1'b0;
            end
            else
            begin
                for (int i = NUM_FAULTS - 1; i >= 0; i--)
                begin
                    if (pending[i])
                        next_event = '{valid: 1'b1, code: 8'(i + 1)};
                end
                for (int i = 0; i < NUM_FAULTS; i++)
                begin
                    if (pending[i] && (pending & ((1 << i) - 1)) == 0)
                        next_pending[i] = 1'b0;
                end
            end
        end
        // new arrivals win over the bit just taken
        next_pending = next_pending | (fault_level & ~fault_prev); // see RULE_06
        if (cycle_short)
            next_short_pend = 1'b1;
        if (next_loss && !param_loss_error)
            next_loss_pend = 1'b1; // see RULE_06
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            fault_prev <= '0;
            pending <= '0;
            short_pend <= 1'b0;
            loss_pend <= 1'b0;
            event_out <= '0;
        end
        else
        begin
            fault_prev <= next_fault_prev;
            pending <= next_pending;
            short_pend <= next_short_pend;
            loss_pend <= next_loss_pend;
            event_out <= next_event;
        end
    end

endmodule

/* rtl/switch_point_link_params.svh */
`ifndef SWITCH_POINT_LINK_PARAMS_SVH
`define SWITCH_POINT_LINK_PARAMS_SVH

// clock and link timing
`define CLK_HZ 20000000
`define LINK_BIT_RATE 38400
`define MIN_CYCLE_US 2300
`define SETTLE_MS 3000

// cyclic word layout
`define PD_WIDTH 16
`define MEAS_WIDTH 14
`define PD_MEAS_LSB 2
`define PD_SP2_BIT 1
`define PD_SP1_BIT 0

// parameter channel
`define PARAM_DEPTH 64
`define SYS_CMD_INDEX 8'h02
`define CMD_STORE 16'h0005
`define PARAM_RESET 16'h0000

// event codes
`define EVT_CODE_WIDTH 8
`define EVT_CYCLE_SHORT 8'hF0
`define EVT_PARAM_LOSS 8'hE1

`endif

/* rtl/switch_point_link_pkg.sv */
package switch_point_link_pkg;

    typedef enum logic [1:0] {
        VARIANT_VACUUM = 2'h0,
        VARIANT_PRESSURE = 2'h1,
        VARIANT_COMBINED = 2'h2
    } variant_t;

    typedef struct packed {
        logic [13:0] meas;
        logic sp2;
        logic sp1;
    } pd_word_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] index;
        logic [15:0] data;
    } param_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } event_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SHIFT = 3'b010,
        TX_DONE = 3'b100
    } tx_state_t;

endpackage

/* verification/switch_point_link_checker.sv */
`timescale 1ns/1ps
module switch_point_link_checker
    import switch_point_link_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // points and pins
    input wire logic point_one_state,
    input wire logic point_two_state,
    input wire logic link_mode,
    input wire logic switch_out_first,
    input wire logic switch_out_first_oe,
    input wire logic switch_out_second,
    input wire logic pd_request,
    // parameters, storage and events
    input wire switch_point_link_pkg::param_req_t master_req,
    input wire logic master_ack,
    input wire switch_point_link_pkg::param_req_t local_req,
    input wire logic store_request,
    input wire logic supply_lost,
    input wire logic param_loss_error,
    input wire switch_point_link_pkg::event_t event_out,
    input wire logic event_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // write strobes of both parameter paths
    wire logic mw = master_req.valid && master_req.write;
    wire logic lw = local_req.valid && local_req.write;
    logic settled;
    logic linked;
    // mode seen at the previous edge, reset edges excluded
    always_ff @(posedge clk)
    begin
        settled <= !reset && !link_mode;
        linked <= !reset && link_mode;
    end

    chk_ack_next: assert property (master_req.valid |=> master_ack)
        else $error("parameter ack missing");
    chk_ack_cause: assert property (master_ack |-> $past(master_req.valid))
        else $error("ack without request");
    chk_out_one: assert property (settled |->
        switch_out_first == $past(point_one_state) && switch_out_first_oe)
        else $error("first output not following point one");
    chk_out_two: assert property (settled |->
        switch_out_second == $past(point_two_state))
        else $error("second output not following point two");
    chk_link_off: assert property (linked |-> !switch_out_second)
        else $error("second output active in link mode");
    chk_store_cmd: assert property (mw && master_req.index == 8'h02 &&
        master_req.data == 16'h0005 |=> store_request)
        else $error("store command without request");
    chk_no_auto: assert property (mw && master_req.index != 8'h02 &&
        !lw && !store_request |=> !store_request)
        else $error("plain master write asked for storage");
    chk_local_store: assert property (lw && !master_req.valid |=>
        store_request)
        else $error("local write without storage request");
    chk_loss_flag: assert property (lw && !master_req.valid && supply_lost
        |=> param_loss_error)
        else $error("loss during write not flagged");
    chk_event_hold: assert property (event_out.valid && !event_ack |=>
        event_out.valid && $stable(event_out.code))
        else $error("event dropped before ack");
    chk_frame_start: assert property (pd_request && link_mode &&
        !switch_out_first_oe && !$past(switch_out_first_oe) &&
        !$past(pd_request) ##1 link_mode [*2] |-> switch_out_first_oe)
        else $error("frame not started two cycles after request");
    cover property (store_request && event_out.valid);
    cover property (link_mode && switch_out_first_oe);
    cover property (param_loss_error);
endmodule

bind switch_point_link_device switch_point_link_checker u_checker (.clk,
    .reset, .point_one_state, .point_two_state, .link_mode, .switch_out_first,
    .switch_out_first_oe, .switch_out_second, .pd_request, .master_req,
    .master_ack, .local_req, .store_request, .supply_lost, .param_loss_error,
    .event_out, .event_ack);

/* verification/link_master_model.sv */
`timescale 1ns/1ps
module link_master_model
    import switch_point_link_pkg::*;
#(
    parameter int BIT_CYCLES = 4
)
(
    // clock
    input wire logic clk,
    // line and device requests
    input wire logic cq_line,
    input wire logic cq_oe,
    input wire switch_point_link_pkg::event_t event_out,
    input wire logic store_request,
    // answers
    input wire logic slow,
    output logic event_ack,
    output logic store_ack,
    // observed traffic
    output logic [15:0] frame,
    output logic [7:0] last_code,
    output int n_ev
);
    int ph = 0;
    int ew = 0;
    int sw = 0;
    int ev_count = 0;
    // one driver for the event count seen by the bench
    assign n_ev = ev_count;
    // sample mid-bit so edge jitter of the sender does not matter
    always @(posedge clk)
    begin
        ph <= cq_oe ? (ph + 1) % BIT_CYCLES : 0;
        if (cq_oe && ph == BIT_CYCLES / 2)
            frame <= {frame[14:0], cq_line};
    end
    // acks come at once or six cycles late; storage enabled on this port
    always @(posedge clk)
    begin
        event_ack <= 1'b0;
        store_ack <= 1'b0;
        ew <= (event_out.valid && !event_ack) ? ew + 1 : 0;
        sw <= (store_request && !store_ack) ? sw + 1 : 0;
        if (event_out.valid && !event_ack && ew >= (slow ? 6 : 0))
        begin
            event_ack <= 1'b1;
            last_code <= event_out.code;
            ev_count <= ev_count + 1;
        end
        if (store_request && !store_ack && sw >= (slow ? 6 : 0))
            store_ack <= 1'b1;
    end
endmodule

/* verification/test_switch_point_link_device.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h, expected %h", $time, g, e); end end
module test_switch_point_link_device;
    import switch_point_link_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic point_one_state = 1'b0;
    logic point_two_state = 1'b0;
    logic signed [15:0] meas_mbar = 16'sh0000;
    logic link_mode = 1'b0;
    logic pd_request = 1'b0;
    param_req_t master_req = '0;
    param_req_t local_req = '0;
    logic [7:0] fault_level = 8'h00;
    logic supply_lost = 1'b0;
    logic param_loss_clear = 1'b0;
    logic slow = 1'b0;
    logic switch_out_first, switch_out_first_oe, switch_out_second;
    logic master_ack, store_request, param_loss_error, event_ack, store_ack;
    logic [15:0] master_rdata, frame, r, w;
    logic [15:0] rs = 16'h0050;
    logic [7:0] last_code;
    event_t event_out;
    int n_ev, k;
    int fails = 0;
    int n_checks = 0;
    logic signed [15:0] corner [4] = '{16'sh2000, 16'shDFFF, 16'sh0000,
        16'shFFFF};
    // released line is held low by the port load
    wire logic cq_line = switch_out_first_oe ? switch_out_first : 1'b0;

    // short counts keep the frames and settle window quick
    switch_point_link_device #(.VARIANT(VARIANT_COMBINED),
        .SETTLE_CYCLES(50), .MIN_CYCLE_CYCLES(100), .BIT_CYCLES(4)) u_dut (
        .clk, .reset, .point_one_state, .point_two_state, .meas_mbar,
        .link_mode, .switch_out_first, .switch_out_first_oe,
        .switch_out_second, .pd_request, .master_req, .master_ack,
        .master_rdata, .local_req, .fault_level, .event_out, .event_ack,
        .store_request, .store_ack, .supply_lost, .param_loss_error,
        .param_loss_clear);
    link_master_model #(.BIT_CYCLES(4)) u_master (.clk, .cq_line,
        .cq_oe(switch_out_first_oe), .event_out, .store_request, .slow,
        .event_ack, .store_ack, .frame, .last_code, .n_ev);

    always #25 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // combined variant saturates to the signed 14-bit range
    function automatic logic [15:0] exp_word(input logic signed [15:0] m,
        input logic a, input logic b);
        logic signed [15:0] c;
        c = (m > 16'sh1FFF) ? 16'sh1FFF : (m < 16'shE000) ? 16'shE000 : m;
        return {c[13:0], b, a};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one master access, answer taken the cycle after
    task automatic mreq(input logic wr, input logic [7:0] i,
        input logic [15:0] d);
        @(posedge clk);
        master_req <= '{1'b1, wr, i, d};
        @(posedge clk);
        master_req <= '0;
        #1;
        `CHK(master_ack, 1'b1)
        r = master_rdata;
    endtask
    // bounded wait for the model to take the next event
    task automatic wait_ev(input logic [7:0] code);
        int old;
        old = n_ev;
        for (k = 0; k < 60 && n_ev == old; k++) cyc(1);
        #1;
        `CHK(last_code, code)
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        cyc(10);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rs = lfsr(rs);
            cyc(1);
            point_one_state <= rs[0];
            point_two_state <= rs[1];
            cyc(1);
            #1;
            `CHK(switch_out_first, rs[0])
            `CHK(switch_out_second, rs[1])
            `CHK(switch_out_first_oe, 1'b1)
        end
        $display("switching test done");
        w = rs;
        for (int i = 3; i < 11; i++)
        begin
            rs = lfsr(rs);
            mreq(1'b1, 8'(i), rs);
            `CHK(store_request, 1'b0)
        end
        rs = w;
        for (int i = 3; i < 11; i++)
        begin
            rs = lfsr(rs);
            mreq(1'b0, 8'(i), 16'h0000);
            `CHK(r, rs)
        end
        mreq(1'b0, 8'h40, 16'h0000);
        `CHK(r, 16'h0000)
        slow <= 1'b1;
        for (int d = 4; d < 6; d++)
        begin
            mreq(1'b1, 8'h02, 16'(d));
            `CHK(store_request, d == 5)
            cyc(12);
        end
        $display("parameter test done");
        // supply drops in the very cycle of a local write
        cyc(1);
        local_req <= '{1'b1, 1'b1, 8'h0C, 16'hA5C3};
        supply_lost <= 1'b1;
        cyc(1);
        local_req <= '0;
        supply_lost <= 1'b0;
        #1;
        `CHK(store_request, 1'b1)
        `CHK(param_loss_error, 1'b1)
        wait_ev(8'hE1);
        mreq(1'b0, 8'h0C, 16'h0000);
        `CHK(r, 16'hA5C3)
        cyc(1);
        param_loss_clear <= 1'b1;
        cyc(1);
        param_loss_clear <= 1'b0;
        cyc(60);
        supply_lost <= 1'b1;
        cyc(1);
        supply_lost <= 1'b0;
        #1;
        `CHK(param_loss_error, 1'b0)
        for (int i = 0; i < 8; i++)
        begin
            cyc(1);
            fault_level <= 8'h01 << i;
            slow <= i[0];
            wait_ev(8'(i + 1));
        end
        cyc(1);
        fault_level <= 8'h00;
        link_mode <= 1'b1;
        $display("event test done");
        // corners first, then random values through the link frame
        for (int i = 0; i < 8; i++)
        begin
            rs = lfsr(rs);
            cyc(4);
            meas_mbar <= (i < 4) ? corner[i] : rs;
            point_one_state <= rs[0];
            point_two_state <= rs[1];
            cyc(1);
            pd_request <= 1'b1;
            cyc(1);
            pd_request <= 1'b0;
            cyc(30);
            #1;
            `CHK(switch_out_second, 1'b0)
            cyc(80);
            #1;
            `CHK(frame, exp_word(meas_mbar, rs[0], rs[1]))
            `CHK(switch_out_first_oe, 1'b0)
        end
        cyc(1);
        pd_request <= 1'b1;
        cyc(1);
        pd_request <= 1'b0;
        // wait out the frame so the second request is taken, yet too early
        cyc(70);
        pd_request <= 1'b1;
        cyc(1);
        pd_request <= 1'b0;
        wait_ev(8'hF0);
        cyc(80);
        $display("link test done");
        test_done();
    end

    // watchdog far beyond the expected run length
    initial
    begin
        cyc(6000);
        fails++;
        $display("ERROR %0t: timeout", $time);
        test_done();
    end
endmodule
